// File: include/sound_pkg.sv
/*
 * Shared constants, types and helpers of the buzzer tone generator.
 * Assumes a 25 MHz system clock and a Wishbone slave with 32-bit data.
 */
package sound_pkg;

	// System clock and internal time base
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned TICK_HZ = 32768;
	localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;

	// Bus geometry
	localparam int unsigned ADR_W = 17;
	localparam int unsigned IDX_W = 15;

	// Register indices, byte address is four times the index
	localparam logic [14:0] IDX_CLOCK_GATE = 15'h506E;
	localparam logic [14:0] IDX_CONTROL = 15'h5180;
	localparam logic [14:0] IDX_FREQ_SEL = 15'h5181;
	localparam logic [14:0] IDX_VOLUME_SEL = 15'h5182;

	// Field positions
	localparam int unsigned GATE_POS = 0;
	localparam int unsigned EN_POS = 0;
	localparam int unsigned MODE_LSB = 2;
	localparam int unsigned DUR_LSB = 4;
	localparam int unsigned FREQ_LSB = 0;
	localparam int unsigned VOL_LSB = 0;

	// Reset values
	localparam logic [7:0] CLOCK_GATE_RST = 8'h00;
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] FREQ_SEL_RST = 8'h00;
	localparam logic [7:0] VOLUME_SEL_RST = 8'h00;

	// One-shot and envelope times in microseconds
	localparam longint unsigned DUR0_US = 15630;
	localparam longint unsigned DUR1_US = 31250;
	localparam longint unsigned DUR2_US = 62500;
	localparam longint unsigned DUR3_US = 125000;

	// Tone frequencies in millihertz
	localparam int unsigned FREQ0_MHZ = 4096000;
	localparam int unsigned FREQ1_MHZ = 3276800;
	localparam int unsigned FREQ2_MHZ = 2730700;
	localparam int unsigned FREQ3_MHZ = 2340600;
	localparam int unsigned FREQ4_MHZ = 2048000;
	localparam int unsigned FREQ5_MHZ = 1638400;
	localparam int unsigned FREQ6_MHZ = 1365300;
	localparam int unsigned FREQ7_MHZ = 1170300;

	// Envelope splits the time into eight steps
	localparam int unsigned ENV_STEP_SHIFT = 6;
	localparam logic [2:0] LEVEL_QUIETEST = 3'h7;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_ONESHOT = 2'b01,
		MODE_ENVELOPE = 2'b10,
		MODE_RESERVED = 2'b11
	} tone_mode_t;

	typedef enum logic [0:0] {
		TONE_IDLE = 1'b0,
		TONE_PLAY = 1'b1
	} tone_state_t;

	// Time code to length in time-base ticks, rounded down
	function automatic logic [12:0] dur_ticks(input logic [1:0] code);
		longint unsigned us;
		case (code)
			2'h0: us = DUR0_US;
			2'h1: us = DUR1_US;
			2'h2: us = DUR2_US;
			default: us = DUR3_US;
		endcase
		return 13'((us * TICK_HZ) / 64'd1_000_000);
	endfunction : dur_ticks

	// Frequency code to tone period in time-base ticks, rounded to nearest
	function automatic logic [4:0] tone_div(input logic [2:0] code);
		int unsigned f;
		case (code)
			3'h0: f = FREQ0_MHZ;
			3'h1: f = FREQ1_MHZ;
			3'h2: f = FREQ2_MHZ;
			3'h3: f = FREQ3_MHZ;
			3'h4: f = FREQ4_MHZ;
			3'h5: f = FREQ5_MHZ;
			3'h6: f = FREQ6_MHZ;
			default: f = FREQ7_MHZ;
		endcase
		return 5'((TICK_HZ * 1000 + f / 2) / f);
	endfunction : tone_div

endpackage : sound_pkg

// File: include/tone_cfg_if.sv
/*
 * Settings and events passed between the register slave and the tone engine.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface tone_cfg_if;
	logic gate;
	logic en;
	logic trig;
	sound_pkg::tone_mode_t mode;
	logic [1:0] dur;
	logic [2:0] freq;
	logic [2:0] vol;
	logic done;

	modport regs (output gate, en, trig, mode, dur, freq, vol, input done);
	modport engine (input gate, en, trig, mode, dur, freq, vol, output done);
endinterface : tone_cfg_if

// File: hdl/sound_regs.sv
/*
 * Classic Wishbone slave holding the four tone generator registers.
 * Assumes single-cycle classic masters; data sits in byte lane 0.
 */
`timescale 1ns/1ps
module sound_regs (
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [sound_pkg::ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Engine side
	tone_cfg_if.regs cfg
);
	logic ack_reg;
	logic [31:0] dat_reg;
	logic gate_reg;
	logic en_reg;
	logic trig_reg;
	sound_pkg::tone_mode_t mode_reg;
	logic [1:0] dur_reg;
	logic [2:0] freq_reg;
	logic [2:0] vol_reg;

	// Decode
	wire logic [sound_pkg::IDX_W-1:0] idx = adr_i[sound_pkg::ADR_W-1:2];
	wire logic take = cyc_i && stb_i && !ack_reg;
	wire logic wr = take && we_i && sel_i[0];
	wire logic wr_gate = wr && (idx == sound_pkg::IDX_CLOCK_GATE);
	wire logic wr_ctl = wr && (idx == sound_pkg::IDX_CONTROL);
	wire logic wr_freq = wr && (idx == sound_pkg::IDX_FREQ_SEL);
	wire logic wr_vol = wr && (idx == sound_pkg::IDX_VOLUME_SEL);
	wire logic [7:0] ctl_rd = {2'h0, dur_reg, mode_reg, 1'b0, en_reg};
	logic [7:0] rd_byte;

	// Read mux, unmapped reads return zero
	always_comb begin
		if (idx == sound_pkg::IDX_CLOCK_GATE) begin
			rd_byte = {7'h00, gate_reg};
		end else if (idx == sound_pkg::IDX_CONTROL) begin
			rd_byte = ctl_rd;
		end else if (idx == sound_pkg::IDX_FREQ_SEL) begin
			rd_byte = {5'h00, freq_reg};
		end else if (idx == sound_pkg::IDX_VOLUME_SEL) begin
			rd_byte = {5'h00, vol_reg};
		end else begin
			rd_byte = 8'h00;
		end
	end

	// Writes; a software set of the enable beats the end-of-tone clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
			gate_reg <= sound_pkg::CLOCK_GATE_RST[sound_pkg::GATE_POS];
			en_reg <= sound_pkg::CONTROL_RST[sound_pkg::EN_POS];
			trig_reg <= 1'b0;
			mode_reg <= sound_pkg::tone_mode_t'(sound_pkg::CONTROL_RST[sound_pkg::MODE_LSB +: 2]);
			dur_reg <= sound_pkg::CONTROL_RST[sound_pkg::DUR_LSB +: 2];
			freq_reg <= sound_pkg::FREQ_SEL_RST[sound_pkg::FREQ_LSB +: 3];
			vol_reg <= sound_pkg::VOLUME_SEL_RST[sound_pkg::VOL_LSB +: 3];
		end else begin
			ack_reg <= take;
			dat_reg <= (take && !we_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			trig_reg <= wr_ctl && dat_i[sound_pkg::EN_POS];
			if (wr_gate) begin
				gate_reg <= dat_i[sound_pkg::GATE_POS];
			end
			if (wr_ctl) begin
				en_reg <= dat_i[sound_pkg::EN_POS];
				mode_reg <= sound_pkg::tone_mode_t'(dat_i[sound_pkg::MODE_LSB +: 2]);
				dur_reg <= dat_i[sound_pkg::DUR_LSB +: 2];
			end else if (cfg.done) begin
				en_reg <= 1'b0;
			end
			if (wr_freq) begin
				freq_reg <= dat_i[sound_pkg::FREQ_LSB +: 3];
			end
			if (wr_vol) begin
				vol_reg <= dat_i[sound_pkg::VOL_LSB +: 3];
			end
		end
	end

	// Outputs
	assign ack_o = ack_reg;
	assign dat_o = dat_reg;
	assign cfg.gate = gate_reg;
	assign cfg.en = en_reg;
	assign cfg.trig = trig_reg;
	assign cfg.mode = mode_reg;
	assign cfg.dur = dur_reg;
	assign cfg.freq = freq_reg;
	assign cfg.vol = vol_reg;

	// Checks on the bus and register fields
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence ctl_write_s;
		wr_ctl;
	endsequence

	ack_single_a: assert property (ack_o |=> !ack_o) else $error("ack held longer than one cycle");
	ack_latency_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack not given in one cycle");
	ctl_reserved_a: assert property (ack_o && $past(!we_i && idx == sound_pkg::IDX_CONTROL)
		|-> dat_o[7:6] == 2'h0 && dat_o[1] == 1'b0) else $error("reserved control bits read nonzero");
	ctl_write_a: assert property (ctl_write_s |=> ctl_rd == ($past(dat_i[7:0]) & 8'h3D))
		else $error("control write not stored");
	gate_write_a: assert property (wr_gate |=> gate_reg == $past(dat_i[0]))
		else $error("clock gate write not stored");
	en_clear_a: assert property (cfg.done && !wr_ctl |=> !en_reg ##1 !trig_reg)
		else $error("enable not cleared at end of tone");
endmodule : sound_regs

// File: hdl/sound_buzzer_generator.sv
/*
 * Buzzer tone generator: register slave plus tone engine driving tone_o.
 * Assumes a 25 MHz clk_i, synchronous reset and a classic Wishbone master.
 */
// Function
// - Generator runs only while the clock gate bit is one; resets to zero.
// - Mode field selects normal, one-shot, envelope; code three reserved; resets zero.
// - Time field sets one-shot length and envelope decay, 15.63 to 125 ms.
// - Control bit zero turns output on or triggers it; zero turns off.
// - Frequency field picks one of eight tones from 4096.0 down to 1170.3 Hz.
// - Volume field sets duty; code zero loudest, code seven quietest.
`timescale 1ns/1ps
module sound_buzzer_generator #(
	parameter int unsigned TICK_CYCLES = sound_pkg::TICK_CYCLES,
	parameter int unsigned TICK_W = 16,
	parameter int unsigned PHASE_W = 16
) (
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [sound_pkg::ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Buzzer
	output logic tone_o
);
	tone_cfg_if cfg ();

	// Register slave
	sound_regs u_regs (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.adr_i(adr_i),
		.sel_i(sel_i),
		.dat_i(dat_i),
		.dat_o(dat_o),
		.ack_o(ack_o),
		.cfg(cfg.regs)
	);

	sound_pkg::tone_state_t state_reg;
	sound_pkg::tone_state_t state_next;
	logic [TICK_W-1:0] tick_reg;
	logic [PHASE_W-1:0] phase_reg;
	logic [12:0] elapsed_reg;
	logic tone_reg;
	logic done_reg;

	// Time base, one pulse per 32768 Hz tick
	wire logic tick = tick_reg == TICK_W'(TICK_CYCLES - 1);
	wire logic [TICK_W-1:0] tick_next = tick ? '0 : tick_reg + TICK_W'(1);

	// Tone period in clock cycles for the selected frequency
	wire logic [PHASE_W-1:0] period = PHASE_W'(sound_pkg::tone_div(cfg.freq) * TICK_CYCLES);
	wire logic phase_wrap = phase_reg >= period - PHASE_W'(1);

	// Timed modes and their end
	wire logic timed = (cfg.mode == sound_pkg::MODE_ONESHOT) || (cfg.mode == sound_pkg::MODE_ENVELOPE);
	wire logic [12:0] dur_len = sound_pkg::dur_ticks(cfg.dur);
	wire logic end_hit = timed && tick && (elapsed_reg == dur_len - 13'h1);
	wire logic start = (cfg.trig && timed) || (cfg.en && cfg.mode == sound_pkg::MODE_NORMAL);

	// Envelope step: eighth of the selected time per level
	wire logic [12:0] step_wide = elapsed_reg >> (sound_pkg::ENV_STEP_SHIFT + 32'(cfg.dur));
	wire logic [3:0] env_sum = {1'b0, cfg.vol} + {1'b0, step_wide[2:0]};
	wire logic env_sat = env_sum[3] || (step_wide[12:3] != 10'h000);
	wire logic [2:0] env_level = env_sat ? sound_pkg::LEVEL_QUIETEST : env_sum[2:0];
	wire logic [2:0] level = (cfg.mode == sound_pkg::MODE_ENVELOPE) ? env_level : cfg.vol;

	// High time is (8 - level) sixteenths of the period
	wire logic [PHASE_W+3:0] high_prod = (PHASE_W+4)'(period) * (PHASE_W+4)'(4'h8 - {1'b0, level});
	wire logic [PHASE_W-1:0] high_len = high_prod[PHASE_W+3:4];

	// Play state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			sound_pkg::TONE_IDLE: begin
				if (start) begin
					state_next = sound_pkg::TONE_PLAY;
				end
			end
			sound_pkg::TONE_PLAY: begin
				if (!cfg.en || cfg.mode == sound_pkg::MODE_RESERVED) begin
					state_next = sound_pkg::TONE_IDLE;
				end else if (end_hit && !cfg.trig) begin
					state_next = sound_pkg::TONE_IDLE;
				end
			end
			default: begin
				state_next = sound_pkg::TONE_IDLE;
			end
		endcase
	end

	// Counter next values
	wire logic [PHASE_W-1:0] phase_next = (state_reg == sound_pkg::TONE_IDLE || phase_wrap) ? '0
		: phase_reg + PHASE_W'(1);
	wire logic restart = state_reg == sound_pkg::TONE_IDLE || cfg.trig;
	wire logic [12:0] elapsed_next = restart ? 13'h0000 : (tick ? elapsed_reg + 13'h1 : elapsed_reg);
	wire logic tone_next = state_next == sound_pkg::TONE_PLAY && phase_reg < high_len;
	wire logic done_next = state_reg == sound_pkg::TONE_PLAY && end_hit && !cfg.trig && cfg.en;

	// Engine registers: state and counters frozen, tone and done cleared while the clock gate is off
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= sound_pkg::TONE_IDLE;
			tick_reg <= '0;
			phase_reg <= '0;
			elapsed_reg <= 13'h0000;
			tone_reg <= 1'b0;
			done_reg <= 1'b0;
		end else if (cfg.gate) begin
			state_reg <= state_next;
			tick_reg <= tick_next;
			phase_reg <= phase_next;
			elapsed_reg <= elapsed_next;
			tone_reg <= tone_next;
			done_reg <= done_next;
		end else begin
			tone_reg <= 1'b0;
			done_reg <= 1'b0;
		end
	end

	// Outputs
	assign cfg.done = done_reg;
	assign tone_o = tone_reg;

	// Checks on the tone engine
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence gate_off_s;
		!cfg.gate;
	endsequence

	sequence held_s;
		$stable(phase_reg) && $stable(elapsed_reg) && !tone_o;
	endsequence

	gate_stop_a: assert property (gate_off_s |=> held_s) else $error("engine ran with clock gate off");
	mode_reserved_a: assert property (cfg.gate && cfg.mode == sound_pkg::MODE_RESERVED |=> !tone_o)
		else $error("tone in reserved mode");
	oneshot_len_a: assert property (done_reg |-> $past(elapsed_reg) == sound_pkg::dur_ticks($past(cfg.dur)) - 1)
		else $error("timed tone length wrong");
	off_quiet_a: assert property (cfg.gate && !cfg.en |=> !tone_o) else $error("tone while output off");
	phase_wrap_a: assert property (cfg.gate && state_reg == sound_pkg::TONE_PLAY && phase_reg == period - PHASE_W'(1)
		&& state_next == sound_pkg::TONE_PLAY && $stable(cfg.freq) |=> phase_reg == '0)
		else $error("tone period wrong");
	duty_high_a: assert property (tone_o |-> $past(phase_reg) < $past(high_len)) else $error("duty too long");
	oneshot_stop_a: assert property (done_reg |-> !tone_o ##1 state_reg == sound_pkg::TONE_IDLE || cfg.trig)
		else $error("tone continued after its time");
	env_level_a: assert property (cfg.mode == sound_pkg::MODE_ENVELOPE |-> level >= cfg.vol)
		else $error("envelope raised the duty");
endmodule : sound_buzzer_generator

// File: verif/buzzer_model.sv
/*
 * Buzzer model: measures the tone drive it receives, one figure per tone period.
 * Assumes tone_i is a registered level on clk_i and rst_i is synchronous, active high.
 */
`timescale 1ns/1ps
module buzzer_model (
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	// Drive from the generator
	input wire logic tone_i,
	// Measurements in clock cycles, and a count of rising edges
	output logic [15:0] period_o,
	output logic [15:0] high_o,
	output logic [15:0] rises_o
);
	logic prev_reg;
	logic [15:0] per_cnt_reg;
	logic [15:0] high_cnt_reg;

	// A rising drive edge closes the period and the high time before it
	always_ff @(posedge clk_i) begin
		prev_reg <= tone_i;
		per_cnt_reg <= per_cnt_reg + 16'h0001;
		if (tone_i) begin
			high_cnt_reg <= high_cnt_reg + 16'h0001;
		end
		if (rst_i) begin
			prev_reg <= 1'b0;
			per_cnt_reg <= 16'h0000; // No unknown count before the first edge
			high_cnt_reg <= 16'h0000;
			period_o <= 16'h0000;
			high_o <= 16'h0000;
			rises_o <= 16'h0000;
		end else if (tone_i && !prev_reg) begin
			period_o <= per_cnt_reg;
			high_o <= high_cnt_reg;
			rises_o <= rises_o + 16'h0001;
			per_cnt_reg <= 16'h0001;
			high_cnt_reg <= 16'h0001;
		end
	end
endmodule : buzzer_model

// File: verif/sound_buzzer_generator_bench.sv
/*
 * Self-checking bench of the buzzer tone generator, with a buzzer model on tone_o.
 * Assumes the design's Wishbone timing and a time base shortened to four clocks a tick.
 */
`timescale 1ns/1ps
module sound_buzzer_generator_bench;
	localparam int TK = 4;
	localparam logic [14:0] GATE = sound_pkg::IDX_CLOCK_GATE;
	localparam logic [14:0] CTL = sound_pkg::IDX_CONTROL;
	localparam logic [14:0] FRQ = sound_pkg::IDX_FREQ_SEL;
	localparam logic [14:0] VOL = sound_pkg::IDX_VOLUME_SEL;
	localparam int DIV [8] = '{8, 10, 12, 14, 16, 20, 24, 28};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [16:0] adr_i = 17'h00000;
	logic [3:0] sel_i = 4'h1;
	logic [31:0] dat_i = 32'h00000000;
	logic [31:0] dat_o;
	logic ack_o;
	logic tone_o;
	logic [15:0] period;
	logic [15:0] high;
	logic [15:0] rises;
	logic [15:0] r;
	logic [7:0] q;
	int errors = 0;
	int checked = 0;
	int cycles = 0;

	sound_buzzer_generator #(.TICK_CYCLES(TK)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .tone_o(tone_o));
	buzzer_model buzzer (.clk_i(clk_i), .rst_i(rst_i), .tone_i(tone_o), .period_o(period), .high_o(high),
		.rises_o(rises));

	// Clock and cycle ceiling
	always #20 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			errors++;
			$display("wrong value at %0t: run too long", $time);
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : wrap_up

	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk_reg

	task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %0d expected %0d", $time, what, got, exp);
		end
	endtask : chk_cnt

	// One classic cycle, held until ack is sampled high
	task automatic wb(input logic [14:0] idx, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {idx, 2'b00};
		dat_i <= {24'h000000, d};
		@(posedge clk_i);
		while (ack_o !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk_i);
		end
		chk_cnt(16'(n < 20), 16'h0001, "bus answer");
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask : wb

	task automatic rd(input logic [14:0] idx, input logic [7:0] exp);
		wb(idx, 1'b0, 8'h00);
		chk_reg(q, exp, "register read");
	endtask : rd

	task automatic quiet(input int n);
		r = rises;
		repeat (n) @(posedge clk_i);
		chk_cnt(rises, r, "tone edges");
	endtask : quiet

	task automatic t_regs();
		rd(GATE, 8'h00);
		rd(CTL, 8'h00);
		rd(FRQ, 8'h00);
		rd(VOL, 8'h00);
		wb(CTL, 1'b1, 8'hFF);
		wb(FRQ, 1'b1, 8'hFF);
		wb(VOL, 1'b1, 8'hFF);
		wb(GATE, 1'b1, 8'hFF);
		wb(15'h5183, 1'b1, 8'hFF);
		rd(GATE, 8'h01);
		rd(CTL, 8'h3D);
		rd(FRQ, 8'h07);
		rd(VOL, 8'h07);
		rd(15'h5183, 8'h00);
		quiet(300);
		wb(GATE, 1'b1, 8'h00);
		wb(FRQ, 1'b1, 8'h00);
		wb(VOL, 1'b1, 8'h00);
		$display("register test done");
	endtask : t_regs

	task automatic t_gate();
		wb(CTL, 1'b1, 8'h01);
		quiet(200);
		wb(GATE, 1'b1, 8'h01);
		repeat (200) @(posedge clk_i);
		chk_cnt(period, 16'(8 * TK), "tone period");
		wb(GATE, 1'b1, 8'h00);
		repeat (3) @(posedge clk_i);
		quiet(200);
		wb(GATE, 1'b1, 8'h01);
		$display("clock gate test done");
	endtask : t_gate

	task automatic t_tone();
		for (int c = 0; c < 8; c++) begin
			wb(FRQ, 1'b1, 8'(c));
			repeat (600) @(posedge clk_i);
			chk_cnt(period, 16'(DIV[c] * TK), "tone period");
			chk_cnt(high, 16'(DIV[c] * TK / 2), "high time");
		end
		wb(FRQ, 1'b1, 8'h00);
		for (int v = 0; v < 8; v++) begin
			wb(VOL, 1'b1, 8'(v));
			repeat (150) @(posedge clk_i);
			chk_cnt(high, 16'(2 * (8 - v)), "high time");
		end
		wb(VOL, 1'b1, 8'h00);
		wb(CTL, 1'b1, 8'h00);
		repeat (40) @(posedge clk_i);
		quiet(200);
		$display("tone test done");
	endtask : t_tone

	task automatic t_shot();
		int t;
		for (int k = 0; k < 4; k++) begin
			t = (512 << k) * TK;
			wb(CTL, 1'b1, 8'(8'h05 | (k << 4)));
			repeat (t * 9 / 10) @(posedge clk_i);
			chk_cnt(period, 16'(8 * TK), "tone period");
			rd(CTL, 8'(8'h05 | (k << 4)));
			repeat (t / 5) @(posedge clk_i);
			rd(CTL, 8'(8'h04 | (k << 4)));
			quiet(100);
		end
		$display("one-shot test done");
	endtask : t_shot

	task automatic t_env();
		wb(CTL, 1'b1, 8'h09);
		repeat (100) @(posedge clk_i);
		chk_cnt(high, 16'h0010, "high time");
		repeat (1850) @(posedge clk_i);
		chk_cnt(high, 16'h0002, "high time");
		repeat (200) @(posedge clk_i);
		rd(CTL, 8'h08);
		wb(CTL, 1'b1, 8'h0D);
		quiet(300);
		$display("envelope test done");
	endtask : t_env

	// Reset, then the scenarios in order
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_gate();
		t_tone();
		t_shot();
		t_env();
		wrap_up();
	end
endmodule : sound_buzzer_generator_bench
